// *** tcp_top.v ***
// timer with channel pin control, counter and register port
//
// What this block does
// - external count clock synchronised before prescaler
// - external clock keeps compare software timer
// - pin released when selection or clock off
// - reset leaves every pin under port control
// - center mode makes every enabled pin output
// - capture mode makes pin an edge input
// - capture edges synchronised, polarity selectable
// - compare mode toggles, clears or sets pin
// - toggle keeps previous level until match
// - edge pwm high at restart, low match
// - low bit set inverts edge pwm polarity
// - center pwm clears up, sets down; low bit set inverts
// - clock select: none, bus, fixed, external
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_top #(
  parameter NCH = 2,
  parameter AW  = 8
) (
  input  wire           core_clk_in,
  input  wire           resetn_in,
  input  wire [AW-1:0]  reg_addr_in,
  input  wire [31:0]    reg_wdata_in,
  input  wire           reg_wr_in,
  input  wire           reg_rd_in,
  output wire [31:0]    reg_rdata_out,
  input  wire           ext_count_clock_in,
  input  wire           fixed_clk_tick_in,
  input  wire [NCH-1:0] channel_pin_in,
  output wire [NCH-1:0] channel_pin_out,
  output wire [NCH-1:0] channel_pin_oe_out,
  input  wire [NCH-1:0] gpio_data_in,
  input  wire [NCH-1:0] gpio_dir_in,
  output wire [NCH-1:0] timer_owns_pin_out,
  output wire           irq_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [AW-1:0] ch_addr;
    input integer idx;
    input [7:0]   off;
    begin
      ch_addr = `TCP_OFF_CH_BASE + idx[7:0] * `TCP_CH_STRIDE + off;
    end
  endfunction

  function prescale_due;
    input [6:0] cnt;
    input [2:0] ps;
    reg   [6:0] msk;
    begin
      msk = (7'h01 << ps) - 7'h01;
      prescale_due = ((cnt & msk) == msk);
    end
  endfunction

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg  [1:0]       clks_r;
  reg  [2:0]       ps_r;
  reg              cpwm_r;
  reg  [15:0]      mod_r;
  reg  [8:0]       status_r;
  reg  [8:0]       status_nxt;
  reg  [8:0]       mask_r;
  wire [2*NCH-1:0] els_r;
  wire [2*NCH-1:0] ms_r;
  wire [16*NCH-1:0] cv_r;
  reg  [31:0]      rdata_r;
  reg  [31:0]      rdata_nxt;

  // ----------------------------------------------------------------
  // counter state
  // ----------------------------------------------------------------
  reg  [15:0]      count_r;
  reg  [15:0]      count_nxt;
  reg              down_r;
  reg              down_nxt;
  reg              cnt_new_r;
  reg  [6:0]       pre_r;
  reg              ext_prev_r;
  reg              ovf_evt;

  wire             ext_sync;
  wire [NCH-1:0]   ch_event;
  wire [NCH-1:0]   ch_capture;
  wire [NCH-1:0]   ch_level;
  wire [NCH-1:0]   ch_drive;
  wire [NCH-1:0]   ch_owns;

  wire wr_ctrl   = reg_wr_in && (reg_addr_in == `TCP_OFF_CTRL);
  wire wr_mod    = reg_wr_in && (reg_addr_in == `TCP_OFF_MODULO);
  wire wr_count  = reg_wr_in && (reg_addr_in == `TCP_OFF_COUNT);
  wire wr_status = reg_wr_in && (reg_addr_in == `TCP_OFF_STATUS);
  wire wr_mask   = reg_wr_in && (reg_addr_in == `TCP_OFF_MASK);

  // ----------------------------------------------------------------
  // clock source selection and prescaler
  // ----------------------------------------------------------------
  tcp_sync u_ext_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    (ext_count_clock_in),
    .sync_out    (ext_sync)
  );

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_sync;
    end
  end

  // a rising edge of the synchronised clock is one source tick;
  // above a quarter of the bus rate edges can be missed
  wire ext_tick = ext_sync && !ext_prev_r;

  reg src_tick;
  always @* begin
    src_tick = 1'b0;
    case (clks_r)
      `TCP_CLKS_NONE:  src_tick = 1'b0;
      `TCP_CLKS_BUS:   src_tick = 1'b1;
      `TCP_CLKS_FIXED: src_tick = fixed_clk_tick_in;
      `TCP_CLKS_EXT:   src_tick = ext_tick;
      default:         src_tick = 1'b0;
    endcase
  end

  wire cnt_tick = src_tick && prescale_due(pre_r, ps_r);

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_r <= 7'h00;
    end else if (wr_count || wr_ctrl) begin
      pre_r <= 7'h00;
    end else if (src_tick) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  wire [15:0] top = (mod_r == 16'h0000) ? `TCP_COUNT_TOP : mod_r;

  always @* begin
    count_nxt = count_r;
    down_nxt  = down_r;
    ovf_evt   = 1'b0;
    if (wr_count) begin
      count_nxt = 16'h0000;
      down_nxt  = 1'b0;
    end else if (cnt_tick) begin
      if (cpwm_r) begin
        if (!down_r && (count_r >= top)) begin
          down_nxt  = 1'b1;
          count_nxt = count_r - 16'h0001;
          ovf_evt   = 1'b1;
        end else if (down_r && (count_r == 16'h0000)) begin
          down_nxt  = 1'b0;
          count_nxt = 16'h0001;
        end else if (down_r) begin
          count_nxt = count_r - 16'h0001;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end else begin
        down_nxt = 1'b0;
        if (count_r >= top) begin
          count_nxt = 16'h0000;
          ovf_evt   = 1'b1;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end
    end
  end

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_r   <= `TCP_RST_COUNT;
      down_r    <= 1'b0;
      cnt_new_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      down_r    <= down_nxt;
      cnt_new_r <= cnt_tick && !wr_count;
    end
  end

  // ----------------------------------------------------------------
  // global control registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clks_r <= `TCP_CLKS_NONE;
      ps_r   <= 3'h0;
      cpwm_r <= 1'b0;
      mod_r  <= `TCP_RST_MODULO;
      mask_r <= 9'h000;
    end else begin
      if (wr_ctrl) begin
        clks_r <= reg_wdata_in[`TCP_CTRL_CLKS_LSB +: 2];
        ps_r   <= reg_wdata_in[`TCP_CTRL_PS_LSB +: 3];
        cpwm_r <= reg_wdata_in[`TCP_CTRL_CPWM_BIT];
      end
      if (wr_mod) begin
        mod_r <= reg_wdata_in[15:0];
      end
      if (wr_mask) begin
        mask_r <= reg_wdata_in[8:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire wr_chc = reg_wr_in && (reg_addr_in == ch_addr(g, `TCP_OFF_CH_CTRL));
      wire wr_chv = reg_wr_in && (reg_addr_in == ch_addr(g, `TCP_OFF_CH_VALUE));

      reg  [1:0]  els_g_r;
      reg  [1:0]  ms_g_r;
      reg  [15:0] cv_g_r;

      // one driver per register: each channel owns its slice
      assign els_r[2*g +: 2]  = els_g_r;
      assign ms_r[2*g +: 2]   = ms_g_r;
      assign cv_r[16*g +: 16] = cv_g_r;

      always @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          els_g_r <= `TCP_ELS_OFF;
          ms_g_r  <= `TCP_MS_CAPTURE;
          cv_g_r  <= 16'h0000;
        end else begin
          if (wr_chc) begin
            els_g_r <= reg_wdata_in[`TCP_CHC_ELS_LSB +: 2];
            ms_g_r  <= reg_wdata_in[`TCP_CHC_MS_LSB +: 2];
          end
          // a capture outranks a software write in the same cycle
          if (ch_capture[g]) begin
            cv_g_r <= count_r;
          end else if (wr_chv) begin
            cv_g_r <= reg_wdata_in[15:0];
          end
        end
      end

      tcp_channel u_ch (
        .core_clk_in  (core_clk_in),
        .resetn_in    (resetn_in),
        .count_in     (count_r),
        .cnt_new_in   (cnt_new_r),
        .down_in      (down_r),
        .value_in     (cv_r[16*g +: 16]),
        .els_in       (els_r[2*g +: 2]),
        .mode_in      (ms_r[2*g +: 2]),
        .cpwm_in      (cpwm_r),
        .clks_in      (clks_r),
        .pin_in       (channel_pin_in[g]),
        .gpio_data_in (gpio_data_in[g]),
        .owns_out     (ch_owns[g]),
        .drive_out    (ch_drive[g]),
        .level_out    (ch_level[g]),
        .capture_out  (ch_capture[g]),
        .event_out    (ch_event[g])
      );

      // port logic keeps the pin unless the channel claims it
      assign channel_pin_out[g]    = ch_owns[g] ? ch_level[g] : gpio_data_in[g];
      assign channel_pin_oe_out[g] = ch_owns[g] ? ch_drive[g] : gpio_dir_in[g];
    end
  endgenerate

  assign timer_owns_pin_out = ch_owns;

  // ----------------------------------------------------------------
  // status flags and interrupt
  // ----------------------------------------------------------------
  reg [8:0] set_vec;
  reg [8:0] clr_vec;
  integer   k;

  always @* begin
    set_vec = 9'h000;
    for (k = 0; k < NCH; k = k + 1) begin
      set_vec[k] = ch_event[k];
    end
    set_vec[`TCP_ST_OVF_BIT] = ovf_evt;
    clr_vec = wr_status ? reg_wdata_in[8:0] : 9'h000;
    // a new event in the clearing cycle survives
    status_nxt = (status_r & ~clr_vec) | set_vec;
  end

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_r <= 9'h000;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq_out = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  integer r;

  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (reg_addr_in == `TCP_OFF_CTRL) begin
      rdata_nxt[`TCP_CTRL_CLKS_LSB +: 2] = clks_r;
      rdata_nxt[`TCP_CTRL_PS_LSB +: 3]   = ps_r;
      rdata_nxt[`TCP_CTRL_CPWM_BIT]      = cpwm_r;
    end else if (reg_addr_in == `TCP_OFF_MODULO) begin
      rdata_nxt[15:0] = mod_r;
    end else if (reg_addr_in == `TCP_OFF_COUNT) begin
      rdata_nxt[15:0] = count_r;
      rdata_nxt[16]   = down_r;
    end else if (reg_addr_in == `TCP_OFF_STATUS) begin
      rdata_nxt[8:0] = status_r;
    end else if (reg_addr_in == `TCP_OFF_MASK) begin
      rdata_nxt[8:0] = mask_r;
    end else begin
      for (r = 0; r < NCH; r = r + 1) begin
        if (reg_addr_in == ch_addr(r, `TCP_OFF_CH_CTRL)) begin
          rdata_nxt[`TCP_CHC_ELS_LSB +: 2] = els_r[2*r +: 2];
          rdata_nxt[`TCP_CHC_MS_LSB +: 2]  = ms_r[2*r +: 2];
          rdata_nxt[4]                     = ch_owns[r];
          rdata_nxt[5]                     = ch_level[r];
        end else if (reg_addr_in == ch_addr(r, `TCP_OFF_CH_VALUE)) begin
          rdata_nxt[15:0] = cv_r[16*r +: 16];
        end
      end
    end
  end

  // data stand only in the cycle after the read strobe
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule

// *** tcp_consts.vh ***
// constants for the timer channel pin control block
`ifndef TCP_CONSTS_VH
`define TCP_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCP_OFF_CTRL        8'h00
`define TCP_OFF_MODULO      8'h04
`define TCP_OFF_COUNT       8'h08
`define TCP_OFF_STATUS      8'h0c
`define TCP_OFF_MASK        8'h10
`define TCP_OFF_CH_BASE     8'h20
`define TCP_CH_STRIDE       8'h08
`define TCP_OFF_CH_CTRL     8'h00
`define TCP_OFF_CH_VALUE    8'h04

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCP_CTRL_CLKS_LSB   0
`define TCP_CTRL_PS_LSB     2
`define TCP_CTRL_CPWM_BIT   5
`define TCP_CHC_ELS_LSB     0
`define TCP_CHC_MS_LSB      2
`define TCP_ST_OVF_BIT      8

// ----------------------------------------------------------------
// encodings and reset values
// ----------------------------------------------------------------
`define TCP_CLKS_NONE       2'h0
`define TCP_CLKS_BUS        2'h1
`define TCP_CLKS_FIXED      2'h2
`define TCP_CLKS_EXT        2'h3
`define TCP_ELS_OFF         2'h0
`define TCP_ELS_RISE        2'h1
`define TCP_ELS_FALL        2'h2
`define TCP_ELS_BOTH        2'h3
`define TCP_ELS_TOGGLE      2'h1
`define TCP_ELS_CLEAR       2'h2
`define TCP_ELS_SET         2'h3
`define TCP_MS_CAPTURE      2'h0
`define TCP_MS_COMPARE      2'h1
`define TCP_RST_CTRL        6'h00
`define TCP_RST_MODULO      16'h0000
`define TCP_RST_COUNT       16'h0000
`define TCP_COUNT_TOP       16'hffff

// ----------------------------------------------------------------
// timing limits on the far side, in bus clock periods
// ----------------------------------------------------------------
`define TCP_EXT_CLK_MIN_DIV 4
`define TCP_CAP_MIN_PULSE   4

`endif

// *** tcp_sync.v ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module tcp_sync (
  input  wire core_clk_in,
  input  wire resetn_in,
  input  wire async_in,
  output wire sync_out
);

  reg stage1_r;
  reg stage2_r;

  // stage1 feeds stage2 only
  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
    end else begin
      stage1_r <= async_in;
      stage2_r <= stage1_r;
    end
  end

  assign sync_out = stage2_r;

endmodule

// *** tcp_channel.v ***
// one timer channel: pin ownership, capture edges, compare and pwm output
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_channel (
  input  wire        core_clk_in,
  input  wire        resetn_in,
  input  wire [15:0] count_in,
  input  wire        cnt_new_in,
  input  wire        down_in,
  input  wire [15:0] value_in,
  input  wire [1:0]  els_in,
  input  wire [1:0]  mode_in,
  input  wire        cpwm_in,
  input  wire [1:0]  clks_in,
  input  wire        pin_in,
  input  wire        gpio_data_in,
  output wire        owns_out,
  output wire        drive_out,
  output wire        level_out,
  output wire        capture_out,
  output wire        event_out
);

  wire pin_sync;
  reg  pin_prev_r;
  reg  [2:0] warm_r;
  reg  level_r;
  reg  level_nxt;

  tcp_sync u_pin_sync (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .async_in    (pin_in),
    .sync_out    (pin_sync)
  );

  wire els_on   = (els_in != `TCP_ELS_OFF);
  wire is_cap   = !cpwm_in && (mode_in == `TCP_MS_CAPTURE);
  wire is_cmp   = !cpwm_in && (mode_in == `TCP_MS_COMPARE);
  wire is_epwm  = !cpwm_in && mode_in[1];
  assign owns_out  = els_on && (clks_in != `TCP_CLKS_NONE);
  assign drive_out = owns_out && !is_cap;
  assign level_out = level_r;

  wire match   = cnt_new_in && (count_in == value_in);
  wire restart = cnt_new_in && (count_in == 16'h0000);
  // sync chain resets low while the pin may idle high: no edges until it holds real samples
  wire rise    = warm_r[2] && pin_sync && !pin_prev_r;
  wire fall    = warm_r[2] && !pin_sync && pin_prev_r;
  // edge polarity chosen by the low and high select bits
  assign capture_out = owns_out && is_cap &&
                       ((els_in[0] && rise) || (els_in[1] && fall));
  // compare with selection off still flags: software timer use
  assign event_out = capture_out || (!is_cap && match);

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_prev_r <= 1'b0;
      warm_r     <= 3'h0;
    end else begin
      pin_prev_r <= pin_sync;
      warm_r     <= {warm_r[1:0], 1'b1};
    end
  end

  always @* begin
    level_nxt = level_r;
    if (!owns_out) begin
      // track the port level so a takeover starts from it
      level_nxt = gpio_data_in;
    end else if (cpwm_in) begin
      if (match) begin
        level_nxt = down_in ^ els_in[0];
      end
    end else if (is_epwm) begin
      if (match) begin
        level_nxt = els_in[0];
      end else if (restart) begin
        level_nxt = !els_in[0];
      end
    end else if (is_cmp && match) begin
      if (els_in == `TCP_ELS_TOGGLE) begin
        level_nxt = !level_r;
      end else begin
        level_nxt = els_in[0];
      end
    end
  end

  always @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end

endmodule

// *** tcp_props.sv ***
// assertion checker for the timer channel pin control top
`timescale 1ns/1ps
`include "tcp_consts.vh"
module tcp_props #(
  parameter NCH = 2,
  parameter AW  = 8
) (
  input logic           core_clk_in,
  input logic           resetn_in,
  input logic [AW-1:0]  reg_addr_in,
  input logic [31:0]    reg_wdata_in,
  input logic           reg_wr_in,
  input logic           reg_rd_in,
  input logic [31:0]    reg_rdata_out,
  input logic           ext_count_clock_in,
  input logic           fixed_clk_tick_in,
  input logic [NCH-1:0] channel_pin_in,
  input logic [NCH-1:0] channel_pin_out,
  input logic [NCH-1:0] channel_pin_oe_out,
  input logic [NCH-1:0] gpio_data_in,
  input logic [NCH-1:0] gpio_dir_in,
  input logic [NCH-1:0] timer_owns_pin_out,
  input logic           irq_out
);
  // ------------------------------
  // shadow of the mode fields
  // ------------------------------
  logic [5:0]     ctrl_r;
  logic [3:0]     chc_r [NCH];
  logic [NCH-1:0] own;
  logic [NCH-1:0] drv;

  // updates on the same edge as the design, so a plain compare lines up
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= 6'h00;
      for (int i = 0; i < NCH; i++)
        chc_r[i] <= 4'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `TCP_OFF_CTRL)
        ctrl_r <= reg_wdata_in[5:0];
      for (int i = 0; i < NCH; i++)
        if (reg_addr_in == AW'(32 + 8 * i))
          chc_r[i] <= reg_wdata_in[3:0];
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      own[i] = chc_r[i][1:0] != 2'h0 && ctrl_r[1:0] != 2'h0;
      drv[i] = own[i] && (ctrl_r[5] || chc_r[i][3:2] != 2'h0);
    end
  end

  // ------------------------------
  // properties
  // ------------------------------
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_rd_ch0;
    reg_rd_in && reg_addr_in == AW'(32);
  endsequence
  sequence s_mask_off;
    reg_wr_in && reg_addr_in == `TCP_OFF_MASK && reg_wdata_in == 32'h0;
  endsequence

  property p_own;
    timer_owns_pin_out == own;
  endproperty
  a_own: assert property (p_own) else $error("pin ownership wrong");
  property p_release;
    (((channel_pin_out ^ gpio_data_in) | (channel_pin_oe_out ^ gpio_dir_in)) & ~own) == '0;
  endproperty
  a_release: assert property (p_release) else $error("released pin not on port");
  property p_oe;
    (channel_pin_oe_out & own) == drv;
  endproperty
  a_oe: assert property (p_oe) else $error("owned pin direction wrong");
  property p_cpwm;
    ctrl_r[5] |-> (channel_pin_oe_out & own) == own;
  endproperty
  a_cpwm: assert property (p_cpwm) else $error("center pin not output");
  property p_rst;
    $rose(resetn_in) |-> timer_owns_pin_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("pin owned after reset");
  property p_rd_ch0;
    s_rd_ch0 |=> reg_rdata_out[4:0] == {own[0], chc_r[0]};
  endproperty
  a_rd_ch0: assert property (p_rd_ch0) else $error("channel control readback wrong");
  property p_rd_idle;
    !reg_rd_in |=> reg_rdata_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_mask_off;
    s_mask_off |=> !irq_out [*2];
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("interrupt with mask clear");
endmodule

bind tcp_top tcp_props #(.NCH(NCH), .AW(AW)) tcp_props_i (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .ext_count_clock_in(ext_count_clock_in),
  .fixed_clk_tick_in(fixed_clk_tick_in), .channel_pin_in(channel_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe_out(channel_pin_oe_out),
  .gpio_data_in(gpio_data_in), .gpio_dir_in(gpio_dir_in),
  .timer_owns_pin_out(timer_owns_pin_out), .irq_out(irq_out)
);

// *** tcp_board.sv ***
// board model: channel pin wires with pull-up and the external count clock
`timescale 1ns/1ps
module tcp_board #(
  parameter NCH = 2
) (
  input  logic           core_clk_in,
  input  logic [NCH-1:0] pin_out_in,
  input  logic [NCH-1:0] pin_oe_in,
  input  logic [NCH-1:0] drv_en_in,
  input  logic [NCH-1:0] drv_val_in,
  input  logic           ext_run_in,
  output logic [NCH-1:0] pin_wire_out,
  output logic           ext_clk_out
);
  logic [1:0] div_r = 2'h0;
  logic       ext_r = 1'b0;

  // pull-up holds an undriven line high; the device side wins any contention
  always_comb begin
    for (int i = 0; i < NCH; i++)
      pin_wire_out[i] = pin_oe_in[i] ? pin_out_in[i] : (drv_en_in[i] ? drv_val_in[i] : 1'b1);
  end

  // own line, never a channel pin; eighth of bus rate leaves sync margin
  always @(posedge core_clk_in) begin
    if (ext_run_in) begin
      div_r <= div_r + 2'h1;
      if (div_r == 2'h3)
        ext_r <= ~ext_r;
    end
  end
  assign ext_clk_out = ext_r;
endmodule

// *** testbench.sv ***
// self-checking bench for the timer channel pin control top
`timescale 1ns/1ps
`include "tcp_consts.vh"
module testbench;
  typedef struct packed {
    logic [1:0] els;
    logic [1:0] mode;
    logic       cpwm;
    logic [1:0] clks;
    logic       own;
    logic       oe;
  } tcp_row_t;

  logic        core_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        ext_run = 1'b0;
  logic        tick = 1'b0;
  logic [1:0]  tick_cnt = 2'h0;
  logic [1:0]  gdata = 2'h1;
  logic [1:0]  gdir = 2'h0;
  logic [1:0]  bval = 2'h0;
  logic [1:0]  ben = 2'h0;
  logic [31:0] rdata, d;
  logic [1:0]  pin_in, pin_out, pin_oe, owns;
  logic        ext_clk, irq;
  int          err_total = 0;
  int          check_count = 0;
  int          h;
  int          lo [4] = '{0, 60, 14, 6};
  int          hi [4] = '{0, 70, 18, 9};
  int          pw [7][4] = '{'{1, 10, 18, 10}, '{1, 9, 18, 8}, '{33, 2, 32, 20}, '{33, 1, 32, 12},
                             '{1, 5, 18, 9}, '{1, 6, 9, 0}, '{1, 7, 9, 9}};
  int          cp [4][4] = '{'{1, 0, 1, 1}, '{1, 1, 0, 0}, '{2, 1, 0, 1}, '{3, 0, 1, 1}};
  tcp_row_t    rows [7] = '{'{2'h0, 2'h1, 1'b0, 2'h1, 1'b0, 1'b0}, '{2'h1, 2'h1, 1'b0, 2'h0, 1'b0, 1'b0},
                            '{2'h1, 2'h0, 1'b0, 2'h1, 1'b1, 1'b0}, '{2'h2, 2'h1, 1'b0, 2'h2, 1'b1, 1'b1},
                            '{2'h3, 2'h2, 1'b0, 2'h3, 1'b1, 1'b1}, '{2'h2, 2'h0, 1'b1, 2'h1, 1'b1, 1'b1},
                            '{2'h0, 2'h1, 1'b0, 2'h3, 1'b0, 1'b0}};

  tcp_top #(.NCH(2), .AW(8)) tcp_top_i (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .ext_count_clock_in(ext_clk),
    .fixed_clk_tick_in(tick), .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe_out(pin_oe), .gpio_data_in(gdata), .gpio_dir_in(gdir),
    .timer_owns_pin_out(owns), .irq_out(irq)
  );
  tcp_board #(.NCH(2)) tcp_board_i (
    .core_clk_in(core_clk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .drv_en_in(ben),
    .drv_val_in(bval), .ext_run_in(ext_run), .pin_wire_out(pin_in), .ext_clk_out(ext_clk)
  );

  // ------------------------------
  // clocking and bus tasks
  // ------------------------------
  always #2.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    tick_cnt <= tick_cnt + 2'h1;
    tick <= tick_cnt == 2'h3;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge core_clk_in);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk_in);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic hcount(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge core_clk_in);
      #1;
      c += int'(pin_out[0] === 1'b1);
    end
  endtask

  initial begin
    repeat (50000) @(posedge core_clk_in);
    err_total++;
    end_of_test();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (6) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    chk(owns, 2'h0);
    chk(pin_out, gdata);
    chk(pin_oe, gdir);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(`TCP_OFF_CTRL, {26'h0, rows[i].cpwm, 3'h0, rows[i].clks});
      wr(8'h20, {28'h0, rows[i].mode, rows[i].els});
      rd(8'h20, d);
      chk(d[4:0], {rows[i].own, rows[i].mode, rows[i].els});
      chk(owns[0], rows[i].own);
      chk(pin_oe[0], rows[i].oe);
    end
    $display("ownership test done");
    ext_run <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(`TCP_OFF_CTRL, c);
      wr(`TCP_OFF_COUNT, 32'h0);
      repeat (64) @(posedge core_clk_in);
      rd(`TCP_OFF_COUNT, d);
      chk(d[15:0] >= lo[c] && d[15:0] <= hi[c], 1'b1);
    end
    ext_run <= 1'b0;
    $display("clock source test done");
    wr(`TCP_OFF_MODULO, 32'h8);
    wr(8'h24, 32'h5);
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h5);
    #1;
    chk(pin_out[0], 1'b1);
    foreach (pw[i]) begin
      wr(`TCP_OFF_CTRL, pw[i][0]);
      wr(8'h20, pw[i][1]);
      wr(`TCP_OFF_COUNT, 32'h0);
      repeat (20) @(posedge core_clk_in);
      hcount(pw[i][2], h);
      chk(h, pw[i][3]);
    end
    $display("pin output test done");
    ben <= 2'h1;
    wr(`TCP_OFF_MASK, 32'h1);
    foreach (cp[i]) begin
      wr(8'h20, cp[i][0]);
      bval[0] <= cp[i][1][0];
      repeat (6) @(posedge core_clk_in);
      wr(`TCP_OFF_STATUS, 32'h1);
      bval[0] <= cp[i][2][0];
      for (int k = 0; k < 8; k++) begin
        @(posedge core_clk_in);
        #1;
        if (irq === 1'b1)
          break;
      end
      chk(irq, cp[i][3]);
      rd(`TCP_OFF_STATUS, d);
      chk(d[0], cp[i][3]);
    end
    wr(`TCP_OFF_MASK, 32'h0);
    #1;
    chk(irq, 1'b0);
    rd(`TCP_OFF_STATUS, d);
    chk(d[0], 1'b1);
    chk(d[`TCP_ST_OVF_BIT], 1'b1);
    wr(`TCP_OFF_STATUS, 32'h1);
    rd(`TCP_OFF_STATUS, d);
    chk(d[0], 1'b0);
    $display("capture test done");
    wr(`TCP_OFF_CTRL, 32'h1);
    wr(8'h20, 32'h5);
    resetn_in <= 1'b0;
    gdata <= 2'h2;
    repeat (6) @(posedge core_clk_in);
    #1;
    chk(owns, 2'h0);
    chk(pin_out, 2'h2);
    @(posedge core_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(owns, 2'h0);
    chk(pin_oe, gdir);
    $display("second reset test done");
    end_of_test();
  end
endmodule
